// ==== common/sdst_regs.vh ====
`ifndef SDST_REGS_VH
`define SDST_REGS_VH

// Register byte addresses on the local register port.
`define SDST_ADDR_TIMING0 8'h8A
`define SDST_ADDR_SHAPE 8'h8B
`define SDST_ADDR_STATUS 8'hF0

// Reset values.
`define SDST_RST_TIMING0 8'h08
`define SDST_RST_SHAPE 8'h00

// Field positions in the first timing register.
`define SDST_T0_MASTER 0
`define SDST_T0_MODE_LO 1
`define SDST_T0_MODE_HI 2
`define SDST_T0_RSVD 3
`define SDST_T0_LDLY_LO 4
`define SDST_T0_LDLY_HI 5
`define SDST_T0_MINLUMA 6
`define SDST_T0_TRESET 7

// Field positions in the sync shape register.
`define SDST_SH_HW_LO 0
`define SDST_SH_HW_HI 1
`define SDST_SH_HV_LO 2
`define SDST_SH_HV_HI 3
`define SDST_SH_VX_LO 4
`define SDST_SH_VX_HI 5

// Field positions in the status register.
`define SDST_ST_MASTER 0
`define SDST_ST_VSYNC 1
`define SDST_ST_HSYNC 2
`define SDST_ST_CNTRST 3

// Timing mode codes.
`define SDST_MODE_0 2'h0
`define SDST_MODE_1 2'h1
`define SDST_MODE_2 2'h2
`define SDST_MODE_3 2'h3

// Horizontal sync width in clock cycles, per code.
`define SDST_HW_CODE0 11'h001
`define SDST_HW_CODE1 11'h004
`define SDST_HW_CODE2 11'h010
`define SDST_HW_CODE3 11'h080

// Horizontal to vertical sync delay in clock cycles, per code.
`define SDST_HV_CODE0 11'h000
`define SDST_HV_CODE1 11'h004
`define SDST_HV_CODE2 11'h008
`define SDST_HV_CODE3 11'h012

// Mode 2 vertical sync width in clock cycles, per code.
`define SDST_VW_CODE0 11'h001
`define SDST_VW_CODE1 11'h004

// Extra rising-edge delay in Mode 1.
`define SDST_TC_EXTRA_US 32
`define SDST_CLK_MHZ 20
`define SDST_TC_EXTRA_CYC (`SDST_TC_EXTRA_US * `SDST_CLK_MHZ)

`endif

// ==== hdl/sdst_line_gen.v ====
`timescale 1ns/10ps
`include "sdst_regs.vh"

// Horizontal and vertical position counters of the SD timing generator.
module sdst_line_gen #(
  parameter H_TOTAL = 858,
  parameter V_TOTAL = 525,
  parameter HW = 11,
  parameter VW = 10
) (
  input wire clk_sys,
  input wire rst_n,
  input wire restart,
  output reg [HW-1:0] h_cnt,
  output reg [VW-1:0] v_cnt
);

  // Counter limits are cut to the counter widths on purpose.
  localparam [31:0] H_LAST_W = H_TOTAL - 1;
  localparam [31:0] V_LAST_W = V_TOTAL - 1;
  localparam [HW-1:0] H_LAST = H_LAST_W[HW-1:0];
  localparam [VW-1:0] V_LAST = V_LAST_W[VW-1:0];

  always @(posedge clk_sys) begin
    if (!rst_n || restart) begin
      h_cnt <= {HW{1'b0}};
      v_cnt <= {VW{1'b0}};
    end else if (h_cnt == H_LAST) begin
      h_cnt <= {HW{1'b0}};
      if (v_cnt == V_LAST) begin
        v_cnt <= {VW{1'b0}};
      end else begin
        v_cnt <= v_cnt + 1'b1;
      end
    end else begin
      h_cnt <= h_cnt + 1'b1;
    end
  end

endmodule

// ==== hdl/sdst_top.v ====
// Chosen here: the plain strobed port.
`timescale 1ns/10ps
`include "sdst_regs.vh"

// How it works
// - Minimum luma bit picks the output floor.
// - Low-high-low on reset bit restarts counters.
// - Sync shape applies only in master mode.
// - Hsync width code: 1, 4, 16, 128.
// - Hsync-to-vsync delay code: 0, 4, 8, 18.
// - Mode 1: bit 4 adds 32 us.
// - Mode 2: vsync width 1 or 4.
module sdst_top #(
  parameter H_TOTAL = 858,
  parameter V_TOTAL = 525,
  parameter VSYNC_LINES = 3,
  parameter LUMA_W = 10,
  parameter [LUMA_W-1:0] LUMA_FLOOR_40IRE = 10'h010,
  parameter [LUMA_W-1:0] LUMA_FLOOR_7P5IRE = 10'h0F0
) (
  input wire clk_sys,
  input wire rst_n,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire [LUMA_W-1:0] luma_in,
  output reg [LUMA_W-1:0] luma_out,
  output reg hsync_n,
  output reg vsync_n
);

  localparam HW = 11;
  localparam VW = 10;
  localparam [31:0] TC_EXTRA_W = `SDST_TC_EXTRA_CYC;
  localparam [31:0] V_SYNC_END_W = VSYNC_LINES;
  localparam [HW-1:0] TC_EXTRA = TC_EXTRA_W[HW-1:0];
  localparam [VW-1:0] V_SYNC_END = V_SYNC_END_W[VW-1:0];

  // States of the timing reset sequence detector.
  localparam [1:0] SEQ_IDLE = 2'h0;
  localparam [1:0] SEQ_LOW = 2'h1;
  localparam [1:0] SEQ_HIGH = 2'h2;

  reg [7:0] timing0;
  reg [7:0] shape;
  reg cnt_rst_seen;
  reg [1:0] seq_state;
  reg [1:0] next_seq_state;
  reg cnt_restart;
  reg next_cnt_restart;
  reg vs_active;
  reg next_vs_active;
  reg next_hsync_n;
  reg next_vsync_n;
  reg [7:0] next_rdata;

  wire [HW-1:0] h_cnt;
  wire [VW-1:0] v_cnt;

  wire wr_t0 = reg_wr && (reg_addr == `SDST_ADDR_TIMING0);
  wire wr_sh = reg_wr && (reg_addr == `SDST_ADDR_SHAPE);
  wire wr_st = reg_wr && (reg_addr == `SDST_ADDR_STATUS);
  wire master = timing0[`SDST_T0_MASTER];
  wire [1:0] mode = timing0[`SDST_T0_MODE_HI:`SDST_T0_MODE_LO];
  wire [1:0] hw_code = shape[`SDST_SH_HW_HI:`SDST_SH_HW_LO];
  wire [1:0] hv_code = shape[`SDST_SH_HV_HI:`SDST_SH_HV_LO];
  wire [1:0] vx_code = shape[`SDST_SH_VX_HI:`SDST_SH_VX_LO];

  function [HW-1:0] hs_width;
    input [1:0] code;
    begin
      case (code)
        2'h0: hs_width = `SDST_HW_CODE0;
        2'h1: hs_width = `SDST_HW_CODE1;
        2'h2: hs_width = `SDST_HW_CODE2;
        default: hs_width = `SDST_HW_CODE3;
      endcase
    end
  endfunction

  function [HW-1:0] hv_delay;
    input [1:0] code;
    begin
      case (code)
        2'h0: hv_delay = `SDST_HV_CODE0;
        2'h1: hv_delay = `SDST_HV_CODE1;
        2'h2: hv_delay = `SDST_HV_CODE2;
        default: hv_delay = `SDST_HV_CODE3;
      endcase
    end
  endfunction

  // Upper vertical width codes are not supported; they fall back to one cycle.
  function [HW-1:0] vs_width;
    input [1:0] code;
    begin
      case (code)
        2'h1: vs_width = `SDST_VW_CODE1;
        default: vs_width = `SDST_VW_CODE0;
      endcase
    end
  endfunction

  wire [HW-1:0] t_a = hs_width(hw_code);
  wire [HW-1:0] t_b = hv_delay(hv_code);
  wire [HW-1:0] t_c = (mode == `SDST_MODE_1 && vx_code[0]) ? t_b + TC_EXTRA : t_b;
  wire [HW-1:0] t_v_end = t_b + vs_width(vx_code);

  sdst_line_gen #(
    .H_TOTAL(H_TOTAL),
    .V_TOTAL(V_TOTAL),
    .HW(HW),
    .VW(VW)
  ) u_line_gen (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .restart(cnt_restart),
    .h_cnt(h_cnt),
    .v_cnt(v_cnt)
  );

  // Software writes to both timing registers.
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      timing0 <= `SDST_RST_TIMING0;
      shape <= `SDST_RST_SHAPE;
    end else begin
      if (wr_t0) begin
        timing0 <= reg_wdata | `SDST_RST_TIMING0;
      end
      if (wr_sh) begin
        shape <= reg_wdata;
      end
    end
  end

  // Only writes count toward the sequence, so a repeated 1 does not re-arm it.
  always @* begin
    next_seq_state = seq_state;
    next_cnt_restart = 1'b0;
    if (wr_t0) begin
      case (seq_state)
        SEQ_LOW: begin
          if (reg_wdata[`SDST_T0_TRESET]) begin
            next_seq_state = SEQ_HIGH;
          end
        end
        SEQ_HIGH: begin
          if (!reg_wdata[`SDST_T0_TRESET]) begin
            next_seq_state = SEQ_LOW;
            next_cnt_restart = 1'b1;
          end
        end
        default: begin
          next_seq_state = reg_wdata[`SDST_T0_TRESET] ? SEQ_IDLE : SEQ_LOW;
        end
      endcase
    end
  end

  // The bit is zero after reset, which already counts as the leading low.
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      seq_state <= SEQ_LOW;
      cnt_restart <= 1'b0;
    end else begin
      seq_state <= next_seq_state;
      cnt_restart <= next_cnt_restart;
    end
  end

  // Sticky status of a counter restart; a new restart beats a clear write.
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt_rst_seen <= 1'b0;
    end else if (cnt_restart) begin
      cnt_rst_seen <= 1'b1;
    end else if (wr_st && reg_wdata[`SDST_ST_CNTRST]) begin
      cnt_rst_seen <= 1'b0;
    end
  end

  // Horizontal and vertical sync generation from the line counters.
  always @* begin
    next_vs_active = vs_active;
    if (v_cnt == {VW{1'b0}} && h_cnt == t_b) begin
      next_vs_active = 1'b1;
    end else if (v_cnt == V_SYNC_END && h_cnt == t_c) begin
      next_vs_active = 1'b0;
    end
    next_hsync_n = 1'b1;
    next_vsync_n = 1'b1;
    if (master) begin
      next_hsync_n = !(h_cnt < t_a);
      case (mode)
        `SDST_MODE_2: begin
          next_vsync_n = !(v_cnt == {VW{1'b0}} && h_cnt >= t_b && h_cnt < t_v_end);
        end
        default: begin
          next_vsync_n = !vs_active;
        end
      endcase
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      vs_active <= 1'b0;
      hsync_n <= 1'b1;
      vsync_n <= 1'b1;
    end else if (cnt_restart) begin
      vs_active <= 1'b0;
      hsync_n <= 1'b1;
      vsync_n <= 1'b1;
    end else begin
      vs_active <= next_vs_active;
      hsync_n <= next_hsync_n;
      vsync_n <= next_vsync_n;
    end
  end

  // Luma floor clamp, one register stage.
  wire [LUMA_W-1:0] luma_floor = timing0[`SDST_T0_MINLUMA] ? LUMA_FLOOR_7P5IRE
                                                            : LUMA_FLOOR_40IRE;

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      luma_out <= {LUMA_W{1'b0}};
    end else begin
      luma_out <= (luma_in < luma_floor) ? luma_floor : luma_in;
    end
  end

  // Read data stand only in the cycle after the read strobe.
  always @* begin
    next_rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `SDST_ADDR_TIMING0: next_rdata = timing0;
        `SDST_ADDR_SHAPE: next_rdata = shape;
        `SDST_ADDR_STATUS: begin
          next_rdata[`SDST_ST_MASTER] = master;
          next_rdata[`SDST_ST_VSYNC] = !vsync_n;
          next_rdata[`SDST_ST_HSYNC] = !hsync_n;
          next_rdata[`SDST_ST_CNTRST] = cnt_rst_seen;
        end
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule

// ==== sim/sdst_chk.sv ====
`timescale 1ns/10ps
module sdst_chk #(
  parameter H_TOTAL = 858,
  parameter V_TOTAL = 525,
  parameter LUMA_W = 10,
  parameter [LUMA_W-1:0] LUMA_FLOOR_40IRE = 10'h010,
  parameter [LUMA_W-1:0] LUMA_FLOOR_7P5IRE = 10'h0F0
) (
  input wire clk_sys,
  input wire rst_n,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire [LUMA_W-1:0] luma_in,
  input wire [LUMA_W-1:0] luma_out,
  input wire hsync_n,
  input wire vsync_n
);
  reg [7:0] t0;
  reg [7:0] sh;
  reg hi_seen;
  reg [11:0] sc;
  reg [11:0] lc;
  reg [19:0] quiet;
  wire fire = reg_wr && reg_addr == 8'h8A && !reg_wdata[7] && hi_seen;
  wire calm = quiet > H_TOTAL * V_TOTAL + 100;
  wire [LUMA_W-1:0] fl = t0[6] ? LUMA_FLOOR_7P5IRE : LUMA_FLOOR_40IRE;
  wire [11:0] ta = sh[1] ? (sh[0] ? 12'h080 : 12'h010) : (sh[0] ? 12'h004 : 12'h001);
  wire [11:0] tb = sh[3] ? (sh[2] ? 12'h012 : 12'h008) : (sh[2] ? 12'h004 : 12'h000);
  wire m2 = t0[2:1] == 2'h2;
  wire [11:0] rise = m2 ? tb + (sh[5:4] == 2'h1 ? 12'h004 : 12'h001) :
    tb + 12'h001 + (t0[2:1] == 2'h1 && sh[4] ? 12'h280 : 12'h000);
  wire [7:0] rdexp = reg_addr == 8'h8A ? t0 : (reg_addr == 8'h8B ? sh : 8'h00);
  // The counters are hidden, so sync edges are timed from the hsync fall of the same line.
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      t0 <= 8'h08;
      sh <= 8'h00;
      hi_seen <= 1'b0;
      quiet <= 20'h00000;
    end else if (reg_wr) begin
      quiet <= 20'h00000;
      if (reg_addr == 8'h8A) t0 <= reg_wdata | 8'h08;
      if (reg_addr == 8'h8A) hi_seen <= reg_wdata[7];
      if (reg_addr == 8'h8B) sh <= reg_wdata;
    end else if (quiet != 20'hFFFFF) begin
      quiet <= quiet + 20'h00001;
    end
    sc <= $fell(hsync_n) ? 12'h001 : (sc == 12'hFFF ? sc : sc + 12'h001);
    lc <= hsync_n ? 12'h000 : lc + 12'h001;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  AST_LUMA: assert property ($past(rst_n) |-> luma_out ==
    ($past(luma_in) > $past(fl) ? $past(luma_in) : $past(fl))) else $error("luma floor wrong");
  AST_RDZ: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  AST_RD: assert property (reg_rd && reg_addr != 8'hF0 |=> reg_rdata == $past(rdexp))
    else $error("read data wrong");
  AST_SLAVE: assert property (!t0[0] && !$past(t0[0]) |-> hsync_n && vsync_n)
    else $error("sync active in slave mode");
  AST_HW: assert property ($rose(hsync_n) && calm |-> lc == ta)
    else $error("hsync width wrong");
  AST_VFALL: assert property ($fell(vsync_n) && calm |->
    ($fell(hsync_n) ? 12'h000 : sc) == tb + (m2 ? 12'h000 : 12'h001)) else $error("vsync fall wrong");
  AST_VRISE: assert property ($rose(vsync_n) && calm |-> sc == rise)
    else $error("vsync rise wrong");
  AST_TRST: assert property (fire && reg_wdata[0] |-> ##2 hsync_n ##1 !hsync_n)
    else $error("timing restart wrong");
endmodule
bind sdst_top sdst_chk #(.H_TOTAL(H_TOTAL), .V_TOTAL(V_TOTAL), .LUMA_W(LUMA_W),
  .LUMA_FLOOR_40IRE(LUMA_FLOOR_40IRE), .LUMA_FLOOR_7P5IRE(LUMA_FLOOR_7P5IRE)) i_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .luma_in(luma_in),
  .luma_out(luma_out), .hsync_n(hsync_n), .vsync_n(vsync_n));

// ==== sim/sdst_src.sv ====
`timescale 1ns/10ps
// Follows the syncs as a downstream source would; only the last complete pulse is kept.
module sdst_src (
  input wire clk_sys,
  input wire hsync_n,
  input wire vsync_n,
  output reg [11:0] hw,
  output reg [11:0] vw
);
  reg [11:0] hc = 12'h000;
  reg [11:0] vc = 12'h000;
  initial hw = 12'h000;
  initial vw = 12'h000;
  always @(posedge clk_sys) begin
    hc <= hsync_n ? 12'h000 : hc + 12'h001;
    vc <= vsync_n ? 12'h000 : vc + 12'h001;
    if (hsync_n && hc != 12'h000) hw <= hc;
    if (vsync_n && vc != 12'h000) vw <= vc;
  end
endmodule

// ==== sim/tb_top.sv ====
`timescale 1ns/10ps
`define CK(n, e, a) begin total_checks = total_checks + 1; if ((a) !== (e)) begin \
  bad_count = bad_count + 1; $display("Error %s expected %h seen %h", n, e, a); end end
module tb_top;
  reg clk_sys = 1'b0;
  reg rst_n = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg [9:0] luma_in = 10'h005;
  wire [7:0] reg_rdata;
  wire [9:0] luma_out;
  wire hsync_n;
  wire vsync_n;
  wire [11:0] hw;
  wire [11:0] vw;
  reg [39:0] rows [0:5];
  integer bad_count = 0;
  integer total_checks = 0;
  integer cycles = 0;
  integer i;
  always #25 clk_sys = ~clk_sys;
  sdst_top #(.H_TOTAL(700), .V_TOTAL(6)) i_sdst_top (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .luma_in(luma_in), .luma_out(luma_out), .hsync_n(hsync_n),
    .vsync_n(vsync_n));
  sdst_src i_sdst_src (.clk_sys(clk_sys), .hsync_n(hsync_n), .vsync_n(vsync_n), .hw(hw),
    .vw(vw));
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 `CK("reg_rdata", e, reg_rdata)
    end
  endtask
  always @(posedge clk_sys) begin
    cycles = cycles + 1;
    if (cycles == 80000) begin
      bad_count = bad_count + 1;
      give_verdict;
    end
  end
  initial begin
    rows[0] = {8'h01, 8'h00, 12'h001, 12'h834};
    rows[1] = {8'h01, 8'h05, 12'h004, 12'h834};
    rows[2] = {8'h03, 8'h1A, 12'h010, 12'hAB4};
    rows[3] = {8'h05, 8'h1F, 12'h080, 12'h004};
    rows[4] = {8'h07, 8'h10, 12'h001, 12'h834};
    rows[5] = {8'h05, 8'h20, 12'h001, 12'h001};
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(8'h8A, 8'h08);
    rd(8'h8B, 8'h00);
    wr(8'h8C, 8'hFF);
    rd(8'h8C, 8'h00);
    `CK("luma floor low", 10'h010, luma_out)
    `CK("hsync_n slave", 1'b1, hsync_n)
    `CK("vsync_n slave", 1'b1, vsync_n)
    $display("reset test done");
    // Each row waits two frames so the partner sees one whole pulse of the new shape.
    for (i = 0; i < 6; i = i + 1) begin
      wr(8'h8A, rows[i][39:32]);
      wr(8'h8B, rows[i][31:24]);
      rd(8'h8B, rows[i][31:24]);
      repeat (9000) @(posedge clk_sys);
      #1 `CK("hsync width", rows[i][23:12], hw)
      `CK("vsync width", rows[i][11:0], vw)
      $display("row %0d done", i);
    end
    wr(8'h8A, 8'h01);
    wr(8'h8A, 8'h81);
    wr(8'h8A, 8'h01);
    @(posedge clk_sys);
    #1 `CK("hsync_n forced", 1'b1, hsync_n)
    @(posedge clk_sys);
    #1 `CK("hsync_n restart", 1'b0, hsync_n)
    // Status: master, vsync active from line start, restart flag; clearing drops the flag.
    rd(8'hF0, 8'h0B);
    wr(8'hF0, 8'h08);
    rd(8'hF0, 8'h03);
    $display("timing restart test done");
    wr(8'h8A, 8'h40);
    repeat (2) @(posedge clk_sys);
    luma_in <= 10'h3FF;
    #1 `CK("luma floor high", 10'h0F0, luma_out)
    repeat (2) @(posedge clk_sys);
    #1 `CK("luma pass", 10'h3FF, luma_out)
    repeat (800) @(posedge clk_sys);
    #1 `CK("hsync_n slave", 1'b1, hsync_n)
    `CK("vsync_n slave", 1'b1, vsync_n)
    $display("luma and slave test done");
    give_verdict;
  end
endmodule
